// [test/css_clock_ctrl_test.sv]
// Self-checking bench for the clock source and start-up block.
// Assumes free-running oscillators and the handed-over AXI4-Lite timing.
module css_clock_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, nrst, divide_by_eight_fuse, clock_output_fuse, sleep_req, wake_req;
    logic [3:0] clock_source_fuse_field, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0] startup_time_fuse_field, s_axi_bresp, s_axi_rresp;
    logic [7:0] factory_trim_3v, rc_trim;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic sys_clk_enable, startup_done, timer2_tick, wdt_tick, clock_output_pin;
    logic clock_output_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire rc_osc_clk, lf_osc_clk, wdt_osc_clk;
    wire primary_clock_input_pin, timer_osc_input_pin, timer_xtal_clk;
    int num_errors, comparisons, cyc, n, c[4];
    int ts[8] = '{2, 2, 3, 3, 3, 2, 0, 0};
    int tu[8] = '{0, 1, 0, 1, 2, 3, 0, 2};
    int tm[8] = '{0, 20, 0, 30, 50, 0, 0, 40};
    int pp[8] = '{8, 8, 14, 14, 14, 8, 10, 10};
    int ko[8] = '{1, 1, 1, 1, 0, 1, 1, 1};

    css_osc_model css_osc_model_i (.rc_osc_clk, .lf_osc_clk, .wdt_osc_clk,
        .primary_clock_input_pin, .timer_osc_input_pin, .timer_xtal_clk);
    // Short time-outs keep each boot to a few hundred cycles
    css_clock_ctrl #(.TO_RC_FAST(20), .TO_RC_SLOW(40), .TO_LF_FAST(30), .TO_LF_SLOW(50))
    css_clock_ctrl_i (.sys_clk, .nrst, .clock_source_fuse_field, .startup_time_fuse_field,
        .divide_by_eight_fuse, .clock_output_fuse, .factory_trim_3v, .rc_osc_clk,
        .lf_osc_clk, .wdt_osc_clk, .primary_clock_input_pin, .timer_osc_input_pin,
        .timer_xtal_clk, .sleep_req, .wake_req, .rc_trim, .sys_clk_enable, .startup_done,
        .timer2_tick, .wdt_tick, .clock_output_pin, .clock_output_oe, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask
    // Each channel drops its valid at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        // Ready stays up, so back-to-back calls never lower and raise it in one step
        chk("bresp", 32'h0, s_axi_bresp);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk($sformatf("reg %0h", a), e, s_axi_rdata);
        chk("rresp", 32'h0, s_axi_rresp);
    endtask
    // Rising edges of enable, watchdog tick, timer tick and output pin
    task automatic cnt(input int k);
        logic [3:0] v, p;
        c = '{default: 0};
        p = 4'hf;
        repeat (k) begin
            @(posedge sys_clk);
            v = {clock_output_pin, timer2_tick, wdt_tick, sys_clk_enable};
            for (int i = 0; i < 4; i++) if (v[i] === 1'b1 && p[i] !== 1'b1) c[i]++;
            p = v;
        end
    endtask
    task automatic wait_done(output int m);
        m = 0;
        while (startup_done !== 1'b1) begin
            @(posedge sys_clk);
            m++;
        end
    endtask
    task automatic boot(input int s, input int t, input logic d8, input int hold);
        clock_source_fuse_field <= 4'(s);
        startup_time_fuse_field <= 2'(t);
        divide_by_eight_fuse <= d8;
        nrst <= 1'b0;
        cnt(hold);
        nrst <= 1'b1;
        wait_done(n);
    endtask

    initial begin
        {nrst, divide_by_eight_fuse, sleep_req, wake_req} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {clock_source_fuse_field, startup_time_fuse_field, s_axi_awaddr} = 10'h0;
        {s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 40'h0;
        factory_trim_3v = 8'h5a;
        clock_output_fuse = 1'b1;
        @(posedge sys_clk);
        boot(2, 2, 1'b1, 6);
        rng("startup", 40 + 13 * 8, 40 + 15 * 8 + 10, n);
        rc(4'hc, 32'h2b);
        rc(4'h0, 32'h5a);
        rc(4'h8, 32'h3);
        cnt(1600);
        rng("div8 pin", 23, 27, c[3]);
        rng("div8 enable", 23, 27, c[0]);
        rng("wdt tick", 86, 91, c[1]);
        $display("test defaults done");
        wr(4'h0, 32'ha5, 4'h1);
        rc(4'h0, 32'ha5);
        wr(4'h0, 32'h11, 4'h0);
        rc(4'h0, 32'ha5);
        wr(4'hc, 32'h0, 4'hf);
        rc(4'hc, 32'h2b);
        wr(4'h8, 32'h0, 4'h1);
        cnt(1600);
        rng("div1 pin", 197, 202, c[3]);
        rc(4'h4, 32'h0);
        cnt(1320);
        rng("crystal tick", 58, 62, c[2]);
        wr(4'h4, 32'h1, 4'h1);
        cnt(1320);
        rng("pin tick", 108, 112, c[2]);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            clock_output_fuse <= 1'(ko[i]);
            boot(ts[i], tu[i], 1'b0, 40);
            rng("pin in reset", 1, 40, c[3]);
            rng("enable in reset", 0, 0, c[0]);
            rng("startup", tm[i] + 13 * pp[i], tm[i] + 15 * pp[i] + 10, n);
            rc(4'hc, {4'(ts[i]), 2'(tu[i]), 2'b01});
            rc(4'h0, 32'h5a);
            rc(4'h8, 32'h0);
            cnt(1400);
            rng("source pin", 1400 / pp[i] - 2, 1400 / pp[i] + 2, c[3]);
            chk("oe", 32'(ko[i]), clock_output_oe);
        end
        $display("test sources done");
        sleep_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sleep_req <= 1'b0;
        cnt(60);
        rng("enable asleep", 0, 0, c[0]);
        chk("done asleep", 32'h0, startup_done);
        wake_req <= 1'b1;
        wait_done(n);
        wake_req <= 1'b0;
        rng("wake", 5 * 10, 7 * 10 + 10, n);
        $display("test sleep done");
        wrap_up();
    end
endmodule

// [test/css_osc_model.sv]
// Free-running oscillators and clock pins seen by the clock block.
// Assumes every phase spans at least three sys_clk periods.
module css_osc_model #(
    parameter int H_RC = 40,
    parameter int H_LF = 70,
    parameter int H_WD = 90,
    parameter int H_EX = 50,
    parameter int H_TP = 60,
    parameter int H_TX = 110
) (
    // Oscillators and clock pins
    output logic rc_osc_clk,
    output logic lf_osc_clk,
    output logic wdt_osc_clk,
    output logic primary_clock_input_pin,
    output logic timer_osc_input_pin,
    output logic timer_xtal_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {rc_osc_clk, lf_osc_clk, wdt_osc_clk} = 3'h0;
        {primary_clock_input_pin, timer_osc_input_pin, timer_xtal_clk} = 3'h0;
    end
    always #H_RC rc_osc_clk = ~rc_osc_clk;
    always #H_LF lf_osc_clk = ~lf_osc_clk;
    always #H_WD wdt_osc_clk = ~wdt_osc_clk;
    // Fixed period, so no cycle-to-cycle jump at all
    always #H_EX primary_clock_input_pin = ~primary_clock_input_pin;
    always #H_TP timer_osc_input_pin = ~timer_osc_input_pin;
    always #H_TX timer_xtal_clk = ~timer_xtal_clk;
endmodule

// [verilog/css_clock_ctrl.sv]
// Clock source select, start-up delay, trim and prescaler control.
// Assumes fuses and oscillators arrive as asynchronous levels; AXI4-Lite on sys_clk.
//
// How it works
// - Source code 0010 selects the internal calibrated RC oscillator, factory default.
// - Every reset loads the factory 3V trim byte into the trim register.
// - Software may overwrite the trim register, e.g. with the 5V trim byte.
// - Watchdog tick never depends on the selected source; the reset time-out only tells 128 kHz from the rest.
// - RC: 6 cycles from sleep, 14 from reset, plus 0, 4.1 or 65 ms.
// - Source code 0011 selects the 128 kHz internal oscillator.
// - 128 kHz: 6 cycles from sleep, 14 from reset, plus 0, 4 or 64 ms.
// - Source code 0000 takes the clock from the primary input pin.
// - External: 6 cycles from sleep, 14 from reset, plus 0, 4.1 or 65 ms.
// - Timer 2 runs from the watch crystal, or the timer pin when selected.
// - With the clock-output fuse set the system clock drives the output pin.
// - That clock output keeps running during reset too.
// - The output pin carries the prescaled clock, or the raw source while in reset and load.
// - The divide-by-eight fuse makes the start-up division eight.
// - Prescaler select resets to 0011 with that fuse, else 0000.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "css_defines.svh"
module css_clock_ctrl
    import css_pkg::*;
#(
    parameter int TO_RC_FAST = `CSS_T_RC_FAST_US * `CSS_CLK_MHZ,
    parameter int TO_RC_SLOW = `CSS_T_RC_SLOW_US * `CSS_CLK_MHZ,
    parameter int TO_LF_FAST = `CSS_T_LF_FAST_US * `CSS_CLK_MHZ,
    parameter int TO_LF_SLOW = `CSS_T_LF_SLOW_US * `CSS_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Fuses, programmed reads high
    input  wire logic [3:0]  clock_source_fuse_field,
    input  wire logic [1:0]  startup_time_fuse_field,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic        clock_output_fuse,
    input  wire logic [7:0]  factory_trim_3v,
    // Oscillators and clock pins
    input  wire logic        rc_osc_clk,
    input  wire logic        lf_osc_clk,
    input  wire logic        wdt_osc_clk,
    input  wire logic        primary_clock_input_pin,
    input  wire logic        timer_osc_input_pin,
    input  wire logic        timer_xtal_clk,
    // Power control
    input  wire logic        sleep_req,
    input  wire logic        wake_req,
    // Clock results
    output logic [7:0]       rc_trim,
    output logic             sys_clk_enable,
    output logic             startup_done,
    output logic             timer2_tick,
    output logic             wdt_tick,
    output logic             clock_output_pin,
    output logic             clock_output_oe,
    // AXI4-Lite write
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    css_top_t s;
    css_top_t next_s;

    logic [21:0] sync_q;
    logic [3:0]  src_s;
    logic [1:0]  dly_s;
    logic        div8_s;
    logic        clkout_s;
    logic [7:0]  trim_s;
    logic        rc_s;
    logic        lf_s;
    logic        wdt_s;
    logic        xtal_s;
    logic        tosc_s;
    logic        txtal_s;
    logic        src_level;
    logic        src_rise;
    logic        ps_tick;
    logic        ps_level;
    logic        wr_fire;
    logic        ck_pin;
    logic        ck_oe;

    css_sync #(
        .W (22)
    ) u_sync (
        .sys_clk (sys_clk),
        .d       ({clock_source_fuse_field, startup_time_fuse_field,
                   divide_by_eight_fuse, clock_output_fuse, factory_trim_3v,
                   rc_osc_clk, lf_osc_clk, wdt_osc_clk, primary_clock_input_pin,
                   timer_osc_input_pin, timer_xtal_clk}),
        .q       (sync_q)
    );

    assign {src_s, dly_s, div8_s, clkout_s, trim_s,
            rc_s, lf_s, wdt_s, xtal_s, tosc_s, txtal_s} = sync_q;

    // Unsupported source codes run from the RC oscillator
    always_comb begin
        case (s.fuse_src)
            `CSS_SRC_EXT: src_level = xtal_s;
            `CSS_SRC_LF:  src_level = lf_s;
            default:      src_level = rc_s;
        endcase
    end

    // Period jumps above 2% only while held in reset
    assign src_rise = src_level & ~s.src_prev;

    css_prescaler u_presc (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .src_level (src_level),
        .src_rise  (src_rise),
        .sel       (s.presc),
        .tick      (ps_tick),
        .level     (ps_level)
    );

    // Reserved start-up code 11 is treated like 00
    function automatic logic [22:0] css_timeout(input logic [3:0] src,
                                                input logic [1:0] dly);
        int t;
        t = 0;
        if (src == `CSS_SRC_LF) begin
            if (dly == `CSS_DLY_FAST) t = TO_LF_FAST;
            else if (dly == `CSS_DLY_SLOW) t = TO_LF_SLOW;
        end else begin
            if (dly == `CSS_DLY_FAST) t = TO_RC_FAST;
            else if (dly == `CSS_DLY_SLOW) t = TO_RC_SLOW;
        end
        return t[22:0];
    endfunction

    function automatic logic [7:0] css_read(input logic [3:0] a, input css_top_t r);
        logic [7:0] v;
        v = 8'h00;
        if (a == `CSS_REG_TRIM) begin
            v = r.trim;
        end else if (a == `CSS_REG_ASYNC) begin
            v = 8'(r.tosc_ext) << `CSS_ASYNC_EXT;
        end else if (a == `CSS_REG_PRESC) begin
            v = {4'h0, r.presc};
        end else if (a == `CSS_REG_STATUS) begin
            v = {r.fuse_src, r.fuse_dly, r.fuse_div8, r.done};
        end
        return v;
    endfunction

    function automatic logic css_mapped(input logic [3:0] a);
        return a == `CSS_REG_TRIM || a == `CSS_REG_ASYNC
            || a == `CSS_REG_PRESC || a == `CSS_REG_STATUS;
    endfunction

    assign wr_fire = s.aw_got && s.w_got && !s.bvalid;

    always_comb begin
        next_s            = s;
        next_s.src_prev   = src_level;
        next_s.wdt_prev   = wdt_s;
        next_s.tosc_prev  = tosc_s;
        next_s.txtal_prev = txtal_s;
        // Watchdog tick is independent of the chosen source
        next_s.wdt_tick   = wdt_s & ~s.wdt_prev;
        next_s.t2_tick    = s.tosc_ext ? (tosc_s & ~s.tosc_prev)
                                       : (txtal_s & ~s.txtal_prev);
        next_s.sys_tick   = 1'b0;

        // Bus writes; the fuse load below takes priority in its cycle
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr  = {s_axi_awaddr[3:2], 2'b00};
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wlane = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = css_mapped(s.waddr) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
            if (s.wlane) begin
                if (s.waddr == `CSS_REG_TRIM) begin
                    next_s.trim = s.wdata;
                end else if (s.waddr == `CSS_REG_ASYNC) begin
                    next_s.tosc_ext = s.wdata[`CSS_ASYNC_EXT];
                end else if (s.waddr == `CSS_REG_PRESC) begin
                    next_s.presc = s.wdata[3:0];
                end
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // Bus reads
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = css_read({s_axi_araddr[3:2], 2'b00}, s);
            next_s.rresp  = css_mapped({s_axi_araddr[3:2], 2'b00})
                          ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;

        // Start-up sequence
        case (s.state)
            CSS_LOAD: begin
                next_s.fuse_src  = src_s;
                next_s.fuse_dly  = dly_s;
                next_s.fuse_div8 = div8_s;
                next_s.trim      = trim_s;
                next_s.presc     = div8_s ? `CSS_PS_DIV8 : `CSS_PS_DIV1;
                next_s.tmo       = css_timeout(src_s, dly_s);
                next_s.state     = CSS_TIMEOUT;
            end
            CSS_TIMEOUT: begin
                // Counted on sys_clk, not on the selected source
                if (s.tmo == 23'h000000) begin
                    next_s.ckcnt = `CSS_CK_RESET;
                    next_s.state = CSS_COUNT;
                end else begin
                    next_s.tmo = s.tmo - 23'h000001;
                end
            end
            CSS_COUNT: begin
                if (src_rise) begin
                    if (s.ckcnt <= 5'h01) begin
                        next_s.state = CSS_RUN;
                    end else begin
                        next_s.ckcnt = s.ckcnt - 5'h01;
                    end
                end
            end
            CSS_RUN: begin
                if (sleep_req) begin
                    next_s.state = CSS_SLEEP;
                end else begin
                    next_s.sys_tick = ps_tick;
                end
            end
            CSS_SLEEP: begin
                if (wake_req) begin
                    next_s.ckcnt = `CSS_CK_WAKE;
                    next_s.state = CSS_COUNT;
                end
            end
            default: begin
                next_s.state = CSS_LOAD;
            end
        endcase
        next_s.done = (next_s.state == CSS_RUN);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s          <= '0;
            s.state    <= CSS_LOAD;
            s.fuse_src <= `CSS_SRC_RC;
            s.awready  <= 1'b1;
            s.wready   <= 1'b1;
            s.arready  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Not reset on purpose: the clock must keep reaching the pin in reset
    always_ff @(posedge sys_clk) begin
        ck_oe  <= clkout_s;
        // Prescaler is held in reset, so the raw source stands in
        ck_pin <= (s.state == CSS_LOAD) ? src_level : ps_level;
    end

    assign clock_output_pin = ck_pin;
    assign clock_output_oe  = ck_oe;
    assign rc_trim        = s.trim;
    assign sys_clk_enable = s.sys_tick;
    assign startup_done   = s.done;
    assign timer2_tick    = s.t2_tick;
    assign wdt_tick       = s.wdt_tick;
    assign s_axi_awready  = s.awready;
    assign s_axi_wready   = s.wready;
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_arready  = s.arready;
    assign s_axi_rvalid   = s.rvalid;
    assign s_axi_rdata    = {24'h000000, s.rdata};
    assign s_axi_rresp    = s.rresp;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence load_seen;
        s.state == CSS_LOAD;
    endsequence

    sequence timeout_over;
        s.state == CSS_TIMEOUT && s.tmo == 23'h000000;
    endsequence

    chk_rc_source: assert property (
        s.state != CSS_LOAD && s.fuse_src == `CSS_SRC_RC |-> src_level == rc_s)
        else $error("RC source not selected");
    chk_lf_source: assert property (
        s.fuse_src == `CSS_SRC_LF |-> src_level == lf_s)
        else $error("128 kHz source not selected");
    chk_ext_source: assert property (
        s.fuse_src == `CSS_SRC_EXT |-> src_level == xtal_s)
        else $error("external source not selected");
    chk_trim_load: assert property (
        load_seen |=> s.trim == $past(trim_s))
        else $error("factory trim not loaded");
    chk_trim_write: assert property (
        wr_fire && s.wlane && s.waddr == `CSS_REG_TRIM && s.state != CSS_LOAD
        |=> rc_trim == $past(s.wdata))
        else $error("trim write lost");
    chk_wdt_free: assert property (
        wdt_s && !s.wdt_prev |=> wdt_tick)
        else $error("watchdog tick missing");
    chk_rc_fast_delay: assert property (
        load_seen ##1 (s.fuse_src == `CSS_SRC_RC && s.fuse_dly == `CSS_DLY_FAST)
        |-> s.tmo == TO_RC_FAST)
        else $error("RC fast delay wrong");
    chk_lf_slow_delay: assert property (
        load_seen ##1 (s.fuse_src == `CSS_SRC_LF && s.fuse_dly == `CSS_DLY_SLOW)
        |-> s.tmo == TO_LF_SLOW)
        else $error("128 kHz slow delay wrong");
    chk_reset_cycles: assert property (
        timeout_over |=> s.state == CSS_COUNT && s.ckcnt == `CSS_CK_RESET)
        else $error("reset cycle count wrong");
    chk_wake_cycles: assert property (
        s.state == CSS_SLEEP && wake_req |=> s.ckcnt == `CSS_CK_WAKE ##0 !startup_done)
        else $error("wake cycle count wrong");
    chk_timer_src: assert property (
        !s.tosc_ext && txtal_s && !s.txtal_prev |=> timer2_tick)
        else $error("timer crystal tick missing");
    chk_clock_out: assert property (
        clkout_s && s.state != CSS_LOAD
        |=> clock_output_oe && clock_output_pin == $past(ps_level))
        else $error("clock output not driven");
    chk_presc_reset: assert property (
        load_seen |=> s.presc == ($past(div8_s) ? `CSS_PS_DIV8 : `CSS_PS_DIV1))
        else $error("prescaler reset value wrong");
    chk_gate_held: assert property (
        s.state != CSS_RUN |=> !sys_clk_enable)
        else $error("clock not gated");
endmodule

// [verilog/css_defines.svh]
// Offsets, field positions, reset values and timing figures for the clock block.
// Assumes a 100 MHz sys_clk and 32-bit word-aligned register offsets.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

`define CSS_CLK_MHZ      100
`define CSS_SRC_EXT      4'h0
`define CSS_SRC_RC       4'h2
`define CSS_SRC_LF       4'h3
`define CSS_DLY_FAST     2'h1
`define CSS_DLY_SLOW     2'h2
`define CSS_CK_WAKE      5'h06
`define CSS_CK_RESET     5'h0e
`define CSS_T_RC_FAST_US 4100
`define CSS_T_RC_SLOW_US 65000
`define CSS_T_LF_FAST_US 4000
`define CSS_T_LF_SLOW_US 64000
`define CSS_PS_DIV1      4'h0
`define CSS_PS_DIV8      4'h3
`define CSS_PS_MAX       4'h8
`define CSS_REG_TRIM     4'h0
`define CSS_REG_ASYNC    4'h4
`define CSS_REG_PRESC    4'h8
`define CSS_REG_STATUS   4'hc
`define CSS_ASYNC_EXT    0
`define CSS_RESP_OKAY    2'h0
`define CSS_RESP_SLVERR  2'h2

`endif

// [verilog/css_pkg.sv]
// Types shared by the clock source and start-up block.
// Assumes css_defines.svh is compiled alongside.
package css_pkg;

    typedef enum logic [2:0] {
        CSS_LOAD, CSS_TIMEOUT, CSS_COUNT, CSS_RUN, CSS_SLEEP
    } css_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
        logic       level;
    } css_ps_t;

    typedef struct packed {
        css_state_t  state;
        logic [3:0]  fuse_src;
        logic [1:0]  fuse_dly;
        logic        fuse_div8;
        logic [7:0]  trim;
        logic        tosc_ext;
        logic [3:0]  presc;
        logic [22:0] tmo;
        logic [4:0]  ckcnt;
        logic        src_prev;
        logic        wdt_prev;
        logic        tosc_prev;
        logic        txtal_prev;
        logic        sys_tick;
        logic        t2_tick;
        logic        wdt_tick;
        logic        done;
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  waddr;
        logic [7:0]  wdata;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } css_top_t;

endpackage

// [verilog/css_prescaler.sv]
// System clock prescaler: divides the selected source by 2^sel for sel up to 8, else by 256.
// Assumes src_rise is a one-cycle pulse per source period.
`include "css_defines.svh"
module css_prescaler
    import css_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Source
    input  wire logic       src_level,
    input  wire logic       src_rise,
    input  wire logic [3:0] sel,
    // Divided clock
    output logic            tick,
    output logic            level
);
    css_ps_t r;
    css_ps_t next_r;

    // Reserved codes fall back to the largest factor, the safe side
    function automatic logic [7:0] css_factor_m1(input logic [3:0] s);
        logic [8:0] f;
        f = 9'h1ff;
        if (s <= `CSS_PS_MAX) begin
            f = 9'(9'h001 << s) - 9'h001;
        end
        return f[7:0];
    endfunction

    logic [7:0] m1;

    always_comb begin
        m1         = css_factor_m1(sel);
        next_r     = r;
        next_r.tick = 1'b0;
        if (src_rise) begin
            next_r.tick = (r.cnt >= m1);
            next_r.cnt  = (r.cnt >= m1) ? 8'h00 : r.cnt + 8'h01;
        end
        // Divide by one passes the source straight through
        next_r.level = (m1 == 8'h00) ? src_level : (next_r.cnt <= (m1 >> 1));
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick  = r.tick;
    assign level = r.level;
endmodule

// [verilog/css_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous levels.
// No reset: the output settles two sys_clk edges after power-up.
module css_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         sys_clk,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } css_sync_st_t;

    css_sync_st_t r;
    css_sync_st_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge sys_clk) begin
        r <= next_r;
    end

    assign q = r.s2;
endmodule
